// File: verilog/scpi_status_event_registers.sv
`timescale 1ns/1ps
`default_nettype none
module scpi_status_event_registers #(
   parameter int                              OBUF_DEPTH       = status_pkg::OBUF_DEPTH,
   parameter logic [status_pkg::CODE_WIDTH-1:0] EMPTY_READ_CODE  = 16'h0001,
   parameter logic [status_pkg::CODE_WIDTH-1:0] UNREAD_CODE      = 16'h0002,
   parameter logic [status_pkg::CODE_WIDTH-1:0] BUFS_FULL_CODE   = 16'h0003
) (
   input  wire logic                              ref_clk,
   input  wire logic                              rst,
   input  wire logic                              psc_stored,
   input  wire logic [7:0]                        nv_ese_mask,
   input  wire logic [7:0]                        nv_sre_mask,
   input  wire logic                              cmd_valid,
   input  wire status_pkg::cmd_t                  cmd_code,
   input  wire logic [15:0]                       cmd_value,
   input  wire logic                              serial_poll,
   input  wire logic                              opc_complete,
   input  wire logic                              new_line_start,
   input  wire logic                              input_buf_full,
   input  wire logic                              selftest_fail,
   input  wire logic                              cal_fail,
   input  wire logic                              exec_err,
   input  wire logic                              syntax_err,
   input  wire logic [status_pkg::CODE_WIDTH-1:0] err_code,
   input  wire logic                              overload_volt,
   input  wire logic                              overload_curr,
   input  wire logic                              overload_ohm,
   input  wire logic                              limit_lo,
   input  wire logic                              limit_hi,
   input  wire logic                              reading_trigger,
   input  wire logic                              fetch_mode,
   input  wire logic                              msg_load,
   input  wire logic                              msg_read,
   input  wire logic                              device_clear,
   output var  logic                              resp_valid,
   output var  logic [15:0]                       resp_data,
   output var  logic [7:0]                        status_byte,
   output var  logic                              srq,
   output var  logic                              stop_readings
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [status_pkg::SE_WIDTH-1:0] standard_event_latch;
   logic [status_pkg::SE_WIDTH-1:0] ese_mask;
   logic [status_pkg::QD_WIDTH-1:0] questionable_data_latch;
   logic [status_pkg::QD_WIDTH-1:0] qde_mask;
   logic [7:0]                      sre_mask;
   logic                            rqs;
   logic                            req_prev;

   // ----------------------------------------
   // combinational terms
   // ----------------------------------------
   logic [status_pkg::SE_WIDTH-1:0] se_set;
   logic [status_pkg::QD_WIDTH-1:0] qd_set;
   logic                            cmd_cls;
   logic                            cmd_esr_q;
   logic                            cmd_qev_q;
   logic                            query_err;
   logic                            any_overload;
   logic                            ext_err;
   logic                            esb_sum;
   logic                            ques_sum;
   logic                            req_now;
   logic [7:0]                      stb_now;
   logic                            next_resp_valid;
   logic [15:0]                     next_resp_data;

   status_side_if #(.CODE_W(status_pkg::CODE_WIDTH)) side ();

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // true in the cycle a given command is handed over
   function automatic logic is_cmd(input logic v, input status_pkg::cmd_t c, input status_pkg::cmd_t want);
      is_cmd = v && (c == want);
   endfunction : is_cmd

   // commands that load an answer into the response port
   function automatic logic is_query(input status_pkg::cmd_t c);
      case (c)
         status_pkg::CMD_ESE_QUERY,
         status_pkg::CMD_ESR_QUERY,
         status_pkg::CMD_SRE_QUERY,
         status_pkg::CMD_STB_QUERY,
         status_pkg::CMD_QUES_EVENT_QUERY,
         status_pkg::CMD_QUES_ENABLE_QUERY,
         status_pkg::CMD_ERR_QUERY,
         status_pkg::CMD_PSC_QUERY: is_query = 1'b1;
         default:                   is_query = 1'b0;
      endcase
   endfunction : is_query

   assign cmd_cls   = is_cmd(cmd_valid, cmd_code, status_pkg::CMD_CLS);
   assign cmd_esr_q = is_cmd(cmd_valid, cmd_code, status_pkg::CMD_ESR_QUERY);
   assign cmd_qev_q = is_cmd(cmd_valid, cmd_code, status_pkg::CMD_QUES_EVENT_QUERY);

   // ----------------------------------------
   // event sources
   // ----------------------------------------
   // query errors: empty read, unanswered response, both buffers jammed
   assign query_err = side.read_empty
                    || (new_line_start && side.mav)
                    || (input_buf_full && side.obuf_full);
   assign any_overload = overload_volt || overload_curr || overload_ohm;
   assign ext_err = selftest_fail || cal_fail || exec_err || syntax_err;

   // bits asked to be set this cycle; unused positions never set
   always_comb begin
      se_set = '0;
      se_set[status_pkg::SE_OPC]    = opc_complete;
      se_set[status_pkg::SE_QUERY]  = query_err;
      se_set[status_pkg::SE_DEVICE] = selftest_fail || cal_fail
                                    || any_overload;
      se_set[status_pkg::SE_EXEC]   = exec_err;
      se_set[status_pkg::SE_SYNTAX] = syntax_err;
      se_set = se_set & status_pkg::SE_IMPL_MASK;
   end

   always_comb begin
      qd_set = '0;
      qd_set[status_pkg::QD_VOLT]     = overload_volt;
      qd_set[status_pkg::QD_CURR]     = overload_curr;
      qd_set[status_pkg::QD_OHM]      = overload_ohm;
      qd_set[status_pkg::QD_LIMIT_LO] = limit_lo;
      qd_set[status_pkg::QD_LIMIT_HI] = limit_hi;
      qd_set = qd_set & status_pkg::QD_IMPL_MASK;
   end

   // ----------------------------------------
   // error queue feed
   // ----------------------------------------
   // one entry per error cycle; an overload on its own adds none.
   // parser codes win over the internally detected query codes.
   assign side.err_push = ext_err || query_err;
   always_comb begin
      if (ext_err) begin
         side.err_push_code = err_code;
      end else if (side.read_empty) begin
         side.err_push_code = EMPTY_READ_CODE;
      end else if (input_buf_full && side.obuf_full) begin
         side.err_push_code = BUFS_FULL_CODE;
      end else begin
         side.err_push_code = UNREAD_CODE;
      end
   end
   assign side.err_pop = is_cmd(cmd_valid, cmd_code, status_pkg::CMD_ERR_QUERY);

   error_fifo #(
      .DEPTH  (status_pkg::ERRQ_DEPTH),
      .CODE_W (status_pkg::CODE_WIDTH)
   ) u_errq (
      .ref_clk (ref_clk),
      .rst     (rst),
      .q       (side.errq)
   );

   // ----------------------------------------
   // output buffer tracking
   // ----------------------------------------
   assign side.msg_load    = msg_load;
   assign side.msg_read    = msg_read;
   assign side.rdg_trigger = reading_trigger;
   assign side.fetch_mode  = fetch_mode;
   assign side.dev_clear   = device_clear;

   message_tracker #(
      .DEPTH (OBUF_DEPTH)
   ) u_msg (
      .ref_clk (ref_clk),
      .rst     (rst),
      .o       (side.obuf)
   );

   // readings must wait while nowhere is left to put them
   assign stop_readings = side.obuf_full;

   // ----------------------------------------
   // standard event latch
   // ----------------------------------------
   // set wins over clear so an event landing on a query is kept for
   // the next read; device clear is deliberately not a clear term
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         standard_event_latch <= status_pkg::SE_RESET;
      end else if (cmd_cls || cmd_esr_q) begin
         standard_event_latch <= se_set;
      end else begin
         standard_event_latch <= standard_event_latch | se_set;
      end
   end

   // ----------------------------------------
   // standard event enable mask
   // ----------------------------------------
   // power-up keeps the saved mask unless the stored clear flag is set
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ese_mask <= psc_stored ? '0 : (nv_ese_mask & status_pkg::SE_IMPL_MASK);
      end else if (is_cmd(cmd_valid, cmd_code, status_pkg::CMD_ESE_WRITE)) begin
         ese_mask <= cmd_value[7:0] & status_pkg::SE_IMPL_MASK;
      end
   end

   // ----------------------------------------
   // questionable data latch
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         questionable_data_latch <= status_pkg::QD_RESET;
      end else if (cmd_cls || cmd_qev_q) begin
         questionable_data_latch <= qd_set;
      end else begin
         questionable_data_latch <= questionable_data_latch | qd_set;
      end
   end

   // ----------------------------------------
   // questionable data enable mask
   // ----------------------------------------
   // unlike the standard mask this one ignores the stored clear flag
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         qde_mask <= '0;
      end else if (is_cmd(cmd_valid, cmd_code, status_pkg::CMD_STAT_PRESET)) begin
         qde_mask <= '0;
      end else if (is_cmd(cmd_valid, cmd_code, status_pkg::CMD_QUES_ENABLE_WRITE)) begin
         qde_mask <= cmd_value & status_pkg::QD_IMPL_MASK;
      end
   end

   // ----------------------------------------
   // service request enable mask
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sre_mask <= psc_stored ? '0 : (nv_sre_mask & status_pkg::SRE_IMPL_MASK);
      end else if (is_cmd(cmd_valid, cmd_code, status_pkg::CMD_SRE_WRITE)) begin
         sre_mask <= cmd_value[7:0] & status_pkg::SRE_IMPL_MASK;
      end
   end

   // ----------------------------------------
   // summary bits
   // ----------------------------------------
   // summaries are not latched: clearing a latch drops its summary at once
   assign esb_sum  = |(standard_event_latch & ese_mask);
   assign ques_sum = |(questionable_data_latch & qde_mask);
   always_comb begin
      stb_now = '0;
      stb_now[status_pkg::STB_QUES] = ques_sum;
      stb_now[status_pkg::STB_MAV]  = side.mav;
      stb_now[status_pkg::STB_ESB]  = esb_sum;
      stb_now[status_pkg::STB_RQS]  = rqs;
   end
   assign req_now = |(stb_now & sre_mask);

   // ----------------------------------------
   // request service
   // ----------------------------------------
   // a fresh enabled summary sets it; a poll or losing the cause clears it.
   // a new cause in the poll cycle wins so the request is not lost.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rqs      <= 1'b0;
         req_prev <= 1'b0;
      end else begin
         req_prev <= req_now;
         if (req_now && !req_prev) begin
            rqs <= 1'b1;
         end else if (serial_poll || !req_now) begin
            rqs <= 1'b0;
         end
      end
   end
   assign srq = rqs;

   // status byte as seen by a serial poll, one cycle behind its sources
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         status_byte <= '0;
      end else begin
         status_byte <= stb_now;
      end
   end

   // ----------------------------------------
   // query answers
   // ----------------------------------------
   // answers carry the plain binary sum; decimal text is left to firmware
   always_comb begin
      next_resp_valid = cmd_valid && is_query(cmd_code);
      next_resp_data  = '0;
      case (cmd_code)
         status_pkg::CMD_ESE_QUERY:         next_resp_data = {8'h00, ese_mask};
         status_pkg::CMD_ESR_QUERY:         next_resp_data = {8'h00, standard_event_latch};
         status_pkg::CMD_SRE_QUERY:         next_resp_data = {8'h00, sre_mask};
         status_pkg::CMD_STB_QUERY:         next_resp_data = {8'h00, stb_now};
         status_pkg::CMD_QUES_EVENT_QUERY:  next_resp_data = questionable_data_latch;
         status_pkg::CMD_QUES_ENABLE_QUERY: next_resp_data = qde_mask;
         status_pkg::CMD_PSC_QUERY:         next_resp_data = {15'h0000, psc_stored};
         status_pkg::CMD_ERR_QUERY: begin
            next_resp_data = side.err_empty ? status_pkg::NO_ERROR_CODE : side.err_head;
         end
         default:                           next_resp_data = '0;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         resp_valid <= 1'b0;
         resp_data  <= '0;
      end else begin
         resp_valid <= next_resp_valid;
         if (next_resp_valid) begin
            resp_data <= next_resp_data;
         end
      end
   end

endmodule : scpi_status_event_registers
`default_nettype wire

// File: verilog/status_pkg.sv
`default_nettype none
package status_pkg;

   // ----------------------------------------
   // register widths and implemented bits
   // ----------------------------------------
   localparam int SE_WIDTH = 8;
   localparam int QD_WIDTH = 16;
   localparam int CODE_WIDTH = 16;
   localparam int ERRQ_DEPTH = 20;
   localparam int OBUF_DEPTH = 8;
   localparam logic [SE_WIDTH-1:0] SE_IMPL_MASK = 8'hbd;
   localparam logic [QD_WIDTH-1:0] QD_IMPL_MASK = 16'h1a03;
   localparam logic [7:0] SRE_IMPL_MASK = 8'h38;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int SE_OPC = 0;
   localparam int SE_QUERY = 2;
   localparam int SE_DEVICE = 3;
   localparam int SE_EXEC = 4;
   localparam int SE_SYNTAX = 5;
   localparam int SE_PON = 7;
   localparam int QD_VOLT = 0;
   localparam int QD_CURR = 1;
   localparam int QD_OHM = 9;
   localparam int QD_LIMIT_LO = 11;
   localparam int QD_LIMIT_HI = 12;
   localparam int STB_QUES = 3;
   localparam int STB_MAV = 4;
   localparam int STB_ESB = 5;
   localparam int STB_RQS = 6;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [SE_WIDTH-1:0] SE_RESET = 8'h80;
   localparam logic [QD_WIDTH-1:0] QD_RESET = 16'h0000;
   localparam logic [CODE_WIDTH-1:0] NO_ERROR_CODE = 16'h0000;

   // commands handed over by the command parser
   typedef enum logic [3:0] {
      CMD_NONE, CMD_CLS, CMD_ESE_WRITE, CMD_ESE_QUERY, CMD_ESR_QUERY,
      CMD_SRE_WRITE, CMD_SRE_QUERY, CMD_STB_QUERY, CMD_QUES_EVENT_QUERY,
      CMD_QUES_ENABLE_WRITE, CMD_QUES_ENABLE_QUERY, CMD_STAT_PRESET,
      CMD_ERR_QUERY, CMD_PSC_QUERY
   } cmd_t;

endpackage : status_pkg
`default_nettype wire

// File: verilog/status_side_if.sv
`timescale 1ns/1ps
`default_nettype none
interface status_side_if #(
   parameter int CODE_W = 16
);
   // error queue side
   logic              err_push;
   logic [CODE_W-1:0] err_push_code;
   logic              err_pop;
   logic [CODE_W-1:0] err_head;
   logic              err_empty;
   // output buffer side
   logic              msg_load;
   logic              msg_read;
   logic              rdg_trigger;
   logic              fetch_mode;
   logic              dev_clear;
   logic              mav;
   logic              obuf_full;
   logic              read_empty;

   modport core (output err_push, err_push_code, err_pop, msg_load, msg_read, rdg_trigger, fetch_mode,
                 dev_clear, input err_head, err_empty, mav, obuf_full, read_empty);
   modport errq (input err_push, err_push_code, err_pop, output err_head, err_empty);
   modport obuf (input msg_load, msg_read, rdg_trigger, fetch_mode, dev_clear,
                 output mav, obuf_full, read_empty);
endinterface : status_side_if
`default_nettype wire

// File: verilog/error_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module error_fifo #(
   parameter int DEPTH  = 20,
   parameter int CODE_W = 16
) (
   input wire logic     ref_clk,
   input wire logic     rst,
   status_side_if.errq  q
);
   localparam int PTR_W = $clog2(DEPTH);
   localparam int CNT_W = $clog2(DEPTH + 1);

   logic [CODE_W-1:0] mem [DEPTH];
   logic [PTR_W-1:0]  rd_ptr;
   logic [PTR_W-1:0]  wr_ptr;
   logic [CNT_W-1:0]  count;
   logic              do_push;
   logic              do_pop;

   function automatic logic [PTR_W-1:0] next_ptr(input logic [PTR_W-1:0] p);
      next_ptr = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
   endfunction : next_ptr

   // a full queue drops new entries so the oldest stay readable
   assign do_push = q.err_push && (count != CNT_W'(DEPTH));
   assign do_pop  = q.err_pop && (count != '0);
   assign q.err_empty = (count == '0);
   assign q.err_head  = mem[rd_ptr];

   // storage, oldest entry comes out first
   always_ff @(posedge ref_clk) begin
      if (do_push) begin
         mem[wr_ptr] <= q.err_push_code;
      end
   end

   // pointers and fill level
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rd_ptr <= '0;
         wr_ptr <= '0;
         count  <= '0;
      end else begin
         if (do_push) wr_ptr <= next_ptr(wr_ptr);
         if (do_pop) rd_ptr <= next_ptr(rd_ptr);
         count <= count + CNT_W'(do_push) - CNT_W'(do_pop);
      end
   end
endmodule : error_fifo
`default_nettype wire

// File: verilog/message_tracker.sv
`timescale 1ns/1ps
`default_nettype none
module message_tracker #(
   parameter int DEPTH = 8
) (
   input wire logic     ref_clk,
   input wire logic     rst,
   status_side_if.obuf  o
);
   localparam int CNT_W = $clog2(DEPTH + 1);

   logic [CNT_W-1:0] count;
   logic             trig_pending;
   logic             do_load;
   logic             do_read;

   assign do_load = o.msg_load && (count != CNT_W'(DEPTH));
   assign do_read = o.msg_read && (count != '0);
   assign o.obuf_full  = (count == CNT_W'(DEPTH));
   assign o.read_empty = o.msg_read && (count == '0);
   // mav stays up while a message is queued or a direct trigger is pending; device clear drops it
   assign o.mav = trig_pending || (count != '0);

   // messages waiting in the output buffer
   always_ff @(posedge ref_clk) begin
      if (rst || o.dev_clear) begin
         count <= '0;
      end else begin
         count <= count + CNT_W'(do_load) - CNT_W'(do_read);
      end
   end

   // a direct reading trigger announces data before it is formatted;
   // in memory mode only the fetched transfer raises mav
   always_ff @(posedge ref_clk) begin
      if (rst || o.dev_clear) begin
         trig_pending <= 1'b0;
      end else if (o.rdg_trigger && !o.fetch_mode) begin
         trig_pending <= 1'b1;
      end else if (o.msg_load) begin
         trig_pending <= 1'b0;
      end
   end
endmodule : message_tracker
`default_nettype wire

// File: dv/status_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port checks on the status block
// ----------------------------------------
module status_monitor (
   input wire logic             ref_clk, rst, cmd_valid, overload_volt, reading_trigger, fetch_mode,
   input wire logic             msg_load, device_clear, resp_valid, srq,
   input wire status_pkg::cmd_t cmd_code,
   input wire logic [15:0]      resp_data,
   input wire logic [7:0]       status_byte
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // write-type codes never answer, so the reply pulse keys off this alone
   logic is_q;
   assign is_q = cmd_valid && !(cmd_code inside {status_pkg::CMD_NONE, status_pkg::CMD_CLS,
      status_pkg::CMD_ESE_WRITE, status_pkg::CMD_SRE_WRITE, status_pkg::CMD_QUES_ENABLE_WRITE,
      status_pkg::CMD_STAT_PRESET});
   sequence s_ovl; overload_volt ##1 !cmd_valid ##1 cmd_valid && cmd_code == status_pkg::CMD_ESR_QUERY; endsequence
   sequence s_dclr; device_clear && !msg_load && !reading_trigger ##1 !(msg_load || reading_trigger) [*3];
   endsequence
   answer_one_a: assert property (is_q |=> resp_valid) else $error("query not answered");
   no_answer_a: assert property (!is_q |=> !resp_valid) else $error("stray answer");
   stb_unused_a: assert property ((status_byte & 8'h87) == 8'h00) else $error("unused stb bit");
   srq_follow_a: assert property (status_byte[6] == $past(srq)) else $error("srq off rqs");
   esr_unused_a: assert property (cmd_valid && cmd_code == status_pkg::CMD_ESR_QUERY |=> (resp_data & 16'hff42) == 16'h0000) else $error("esr unused bit");
   ques_unused_a: assert property (cmd_valid && cmd_code == status_pkg::CMD_QUES_EVENT_QUERY |=> (resp_data & 16'he5fc) == 16'h0000) else $error("ques unused bit");
   overload_dev_a: assert property (s_ovl |=> resp_data[3]) else $error("overload lost");
   mav_rise_a: assert property (reading_trigger && !fetch_mode |-> ##[1:2] status_byte[4]) else $error("mav late");
   dclr_mav_a: assert property (s_dclr |=> !status_byte[4]) else $error("mav after clear");
endmodule : status_monitor
bind scpi_status_event_registers status_monitor status_monitor_i (.*);
`default_nettype wire

// File: dv/bus_ctl.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// bus controller: commands, poll, device clear
// ----------------------------------------
module bus_ctl (
   input  wire logic             ref_clk,
   output var  logic             cmd_valid,
   output var  status_pkg::cmd_t cmd_code,
   output var  logic [15:0]      cmd_value,
   output var  logic             serial_poll,
   output var  logic             device_clear
);
   initial begin
      {cmd_valid, cmd_value, serial_poll, device_clear} = '0;
      cmd_code = status_pkg::CMD_NONE;
   end
   // one request per call; value inverted afterwards so a stale field never looks valid
   task send(input status_pkg::cmd_t c, input logic [15:0] v, input logic sp, input logic dc);
      @(negedge ref_clk);
      cmd_valid = (c != status_pkg::CMD_NONE);
      cmd_code  = c;
      {cmd_value, serial_poll, device_clear} = {v, sp, dc};
      @(negedge ref_clk);
      {cmd_valid, serial_poll, device_clear} = 3'b000;
      cmd_value = ~v;
   endtask : send
endmodule : bus_ctl
`default_nettype wire

// File: dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   typedef struct packed {logic [14:0] ev; logic [7:0] esr; logic [15:0] ques; logic [15:0] err;} row_t;
   logic             ref_clk, rst, cmd_valid, serial_poll, device_clear, resp_valid, srq, stop_readings;
   logic             psc_stored, fetch_mode;
   logic [14:0]      ev;
   logic [15:0]      err_code, cmd_value, resp_data;
   logic [7:0]       status_byte;
   status_pkg::cmd_t cmd_code;
   int               failures, n_tests;
   // one event per row with the latch, questionable and queue results it should leave
   row_t rows [11] = '{'{15'h0001, 8'h01, 16'h0000, 16'h0000}, '{15'h0002, 8'h10, 16'h0000, 16'h0a5a},
      '{15'h0004, 8'h20, 16'h0000, 16'h0a5a}, '{15'h0008, 8'h08, 16'h0000, 16'h0a5a},
      '{15'h0010, 8'h08, 16'h0000, 16'h0a5a}, '{15'h0020, 8'h08, 16'h0001, 16'h0000},
      '{15'h0040, 8'h08, 16'h0002, 16'h0000}, '{15'h0080, 8'h08, 16'h0200, 16'h0000},
      '{15'h0100, 8'h00, 16'h0800, 16'h0000}, '{15'h0200, 8'h00, 16'h1000, 16'h0000},
      '{15'h0400, 8'h04, 16'h0000, 16'h0001}};
   bus_ctl bus_ctl_i (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_value(cmd_value),
      .serial_poll(serial_poll), .device_clear(device_clear));
   scpi_status_event_registers scpi_status_event_registers_i (.ref_clk(ref_clk), .rst(rst),
      .psc_stored(psc_stored), .nv_ese_mask(8'h0f), .nv_sre_mask(8'h00), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .cmd_value(cmd_value), .serial_poll(serial_poll), .opc_complete(ev[0]),
      .new_line_start(ev[11]), .input_buf_full(ev[14]), .selftest_fail(ev[3]), .cal_fail(ev[4]),
      .exec_err(ev[1]), .syntax_err(ev[2]), .err_code(err_code), .overload_volt(ev[5]),
      .overload_curr(ev[6]), .overload_ohm(ev[7]), .limit_lo(ev[8]), .limit_hi(ev[9]),
      .reading_trigger(ev[12]), .fetch_mode(fetch_mode), .msg_load(ev[13]), .msg_read(ev[10]),
      .device_clear(device_clear), .resp_valid(resp_valid), .resp_data(resp_data),
      .status_byte(status_byte), .srq(srq), .stop_readings(stop_readings));
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   task chk(input logic [15:0] g, input logic [15:0] e);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   // an absent reply shows as unknown and cannot match
   task q(input status_pkg::cmd_t c, input logic [15:0] e);
      bus_ctl_i.send(c, 16'h0000, 1'b0, 1'b0);
      chk(resp_valid ? resp_data : 16'hxxxx, e);
   endtask : q
   task pulse(input logic [14:0] e);
      @(negedge ref_clk);
      ev = e;
      @(negedge ref_clk);
      ev = '0;
   endtask : pulse
   task end_of_test;
      $display("failures %0d n_tests %0d", failures, n_tests);
      if (failures == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_of_test
   // watchdog well beyond the few hundred cycles the sequence needs
   initial begin
      #40000;
      failures++;
      end_of_test;
   end
   initial begin
      rst = 1'b1; ev = '0; err_code = 16'h0a5a; failures = 0; n_tests = 0;
      {psc_stored, fetch_mode} = 2'b00;
      repeat (10) @(negedge ref_clk);
      rst = 1'b0;
      q(status_pkg::CMD_ESR_QUERY, 16'h0080);
      q(status_pkg::CMD_ESE_QUERY, 16'h000d);
      q(status_pkg::CMD_QUES_ENABLE_QUERY, 16'h0000);
      foreach (rows[i]) begin
         pulse(rows[i].ev);
         q(status_pkg::CMD_ESR_QUERY, {8'h00, rows[i].esr});
         q(status_pkg::CMD_QUES_EVENT_QUERY, rows[i].ques);
         q(status_pkg::CMD_ERR_QUERY, rows[i].err);
         q(status_pkg::CMD_ERR_QUERY, 16'h0000);
      end
      pulse(15'h0002);
      bus_ctl_i.send(status_pkg::CMD_NONE, 16'h0000, 1'b0, 1'b1);
      q(status_pkg::CMD_ESR_QUERY, 16'h0010);
      err_code = 16'h0b0b;
      pulse(15'h0024);
      bus_ctl_i.send(status_pkg::CMD_CLS, 16'h0000, 1'b0, 1'b0);
      q(status_pkg::CMD_ESR_QUERY, 16'h0000);
      q(status_pkg::CMD_QUES_EVENT_QUERY, 16'h0000);
      q(status_pkg::CMD_ERR_QUERY, 16'h0a5a);
      q(status_pkg::CMD_ERR_QUERY, 16'h0b0b);
      bus_ctl_i.send(status_pkg::CMD_ESE_WRITE, 16'h0001, 1'b0, 1'b0);
      bus_ctl_i.send(status_pkg::CMD_SRE_WRITE, 16'h0020, 1'b0, 1'b0);
      pulse(15'h0001);
      repeat (3) @(negedge ref_clk);
      chk({srq, status_byte}, 16'h0160);
      bus_ctl_i.send(status_pkg::CMD_NONE, 16'h0000, 1'b1, 1'b0);
      @(negedge ref_clk);
      chk({srq, status_byte}, 16'h0020);
      q(status_pkg::CMD_ESR_QUERY, 16'h0001);
      repeat (2) @(negedge ref_clk);
      chk(status_byte, 16'h0000);
      bus_ctl_i.send(status_pkg::CMD_ESE_WRITE, 16'hffff, 1'b0, 1'b0);
      q(status_pkg::CMD_ESE_QUERY, 16'h00bd);
      bus_ctl_i.send(status_pkg::CMD_ESE_WRITE, 16'h0000, 1'b0, 1'b0);
      q(status_pkg::CMD_ESE_QUERY, 16'h0000);
      bus_ctl_i.send(status_pkg::CMD_QUES_ENABLE_WRITE, 16'hffff, 1'b0, 1'b0);
      q(status_pkg::CMD_QUES_ENABLE_QUERY, 16'h1a03);
      bus_ctl_i.send(status_pkg::CMD_STAT_PRESET, 16'h0000, 1'b0, 1'b0);
      q(status_pkg::CMD_QUES_ENABLE_QUERY, 16'h0000);
      pulse(15'h1000);
      @(negedge ref_clk);
      chk(status_byte & 8'h10, 16'h0010);
      repeat (8) pulse(15'h2000);
      chk(stop_readings, 16'h0001);
      pulse(15'h4000);
      q(status_pkg::CMD_ESR_QUERY, 16'h0004);
      q(status_pkg::CMD_ERR_QUERY, 16'h0003);
      pulse(15'h0800);
      q(status_pkg::CMD_ESR_QUERY, 16'h0004);
      q(status_pkg::CMD_ERR_QUERY, 16'h0002);
      bus_ctl_i.send(status_pkg::CMD_NONE, 16'h0000, 1'b0, 1'b1);
      repeat (3) @(negedge ref_clk);
      chk({stop_readings, status_byte & 8'h10}, 16'h0000);
      fetch_mode = 1'b1;
      pulse(15'h1000);
      @(negedge ref_clk);
      chk(status_byte & 8'h10, 16'h0000);
      pulse(15'h2000);
      @(negedge ref_clk);
      chk(status_byte & 8'h10, 16'h0010);
      pulse(15'h0400);
      @(negedge ref_clk);
      chk(status_byte & 8'h10, 16'h0000);
      psc_stored = 1'b1;
      rst = 1'b1;
      repeat (10) @(negedge ref_clk);
      rst = 1'b0;
      q(status_pkg::CMD_PSC_QUERY, 16'h0001);
      q(status_pkg::CMD_ESE_QUERY, 16'h0000);
      q(status_pkg::CMD_ESR_QUERY, 16'h0080);
      end_of_test;
   end
endmodule : tb
`default_nettype wire
